// >>> rtl/stepper_mode_switch_and_fault_latch.sv
// step position remapping on resolution change and output protection sequencer
// inputs from pins are synchronised here; bridge outputs feed the chopper stage
`timescale 1ns/10ps
`default_nettype none

module stepper_mode_switch_and_fault_latch
   import stepper_guard_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic stepClk,
   input wire logic forward,
   input wire logic resolution_sel0,
   input wire logic resolution_sel1,
   input wire logic resolution_sel2,
   input wire logic chip_active,
   input wire logic shortDetect,
   input wire logic thermal_trip,
   output logic [8:0] position,
   output logic outputsOn,
   output logic standbyLatched,
   output logic fault_warning_n_o,
   output logic fault_warning_n_oe
);

   // -------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------
   logic [6:0] meta_q;
   logic [6:0] sync_q;
   logic stepPrev_q;
   wire logic [6:0] rawIn = {stepClk, forward, resolution_sel2, resolution_sel1,
                             resolution_sel0, chip_active, shortDetect};

   always_ff @(posedge clock) begin
      meta_q <= rawIn;
      sync_q <= meta_q;
      stepPrev_q <= sync_q[6];
   end

   wire logic [2:0] resIn = sync_q[4:2];
   wire logic activeS = sync_q[1];
   wire logic shortS = sync_q[0];

   // -------------------------------------------------------------
   // thermal indication
   // -------------------------------------------------------------
   // a slow level, yet still two flops: a half-settled trip must not
   // split the bridge enable and the warning onto different cycles
   logic thermMeta_q;
   logic thermal_q;
   always_ff @(posedge clock) begin
      thermMeta_q <= thermal_trip;
      thermal_q <= thermMeta_q;
   end

   // -------------------------------------------------------------
   // step command
   // -------------------------------------------------------------
   step_cmd_t cmd;
   assign cmd = '{
      stepEdge: sync_q[6] & ~stepPrev_q,
      forward: sync_q[5],
      resolution: resIn
   };

   // -------------------------------------------------------------
   // position engine
   // -------------------------------------------------------------
   logic [8:0] pos_q;
   logic [8:0] pos_d;
   logic [2:0] res_q;

   // step size of a resolution in fine units: full 128, half 64 ... 1/128 is 1
   wire logic [8:0] newStep = (cmd.resolution == 3'h0) ? QUAD_SPAN :
                              (QUAD_SPAN >> cmd.resolution);
   wire logic [8:0] quadBase = {pos_q[8:7], 7'h00};
   wire logic toFull = (cmd.resolution == 3'h0) && (res_q != 3'h0);
   wire logic fromFull = (res_q == 3'h0) && (cmd.resolution != 3'h0);
   wire logic stayFull = (cmd.resolution == 3'h0) && (res_q == 3'h0);
   // microstep to full: diagonal of the quadrant holding the position; a position on a
   // boundary opens the next quadrant, so forward from a quadrant end lands on the
   // following (negative) diagonal
   wire logic [8:0] fullTarget = quadBase + DIAG_OFFSET;
   // full-step running moves diagonal to diagonal, one whole quadrant per step
   wire logic [8:0] fullNext = cmd.forward ? (pos_q + QUAD_SPAN) : (pos_q - QUAD_SPAN);
   // next grid point of the new resolution in the running direction
   wire logic [8:0] gridMask = ~(newStep - 9'h001);
   wire logic [8:0] alignDown = pos_q & gridMask;
   wire logic aligned = (alignDown == pos_q);
   wire logic [8:0] nextFwd = alignDown + newStep;
   wire logic [8:0] nextRev = aligned ? (pos_q - newStep) : alignDown;
   wire logic [8:0] microTarget = cmd.forward ? nextFwd : nextRev;

   always_comb begin
      pos_d = pos_q;
      if (cmd.stepEdge) begin
         if (toFull) begin
            pos_d = fullTarget;
         end else if (fromFull) begin
            pos_d = microTarget;
         end else if (stayFull) begin
            pos_d = fullNext;
         end else begin
            pos_d = microTarget;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pos_q <= POS_RESET;
         res_q <= RES_RESET;
      end else begin
         pos_q <= pos_d;
         if (cmd.stepEdge) begin
            res_q <= cmd.resolution;
         end
      end
   end

   // -------------------------------------------------------------
   // short protection sequencer
   // -------------------------------------------------------------
   prot_state_t state_q;
   prot_state_t state_d;
   logic [TIMER_W-1:0] timer_q;
   logic [TIMER_W-1:0] timer_d;

   localparam logic [TIMER_W-1:0] DETECT_LAST = TIMER_W'(SHORT_DETECT_CYC - 1);
   localparam logic [TIMER_W-1:0] LATCH_LAST = TIMER_W'(LATCH_PERIOD_CYC - 1);

   always_comb begin
      state_d = state_q;
      timer_d = timer_q + 1'b1;
      case (state_q)
         PROT_RUN: begin
            timer_d = '0;
            if (shortS) begin
               state_d = PROT_DETECT;
            end
         end
         PROT_DETECT: begin
            if (!shortS) begin
               state_d = PROT_RUN;
               timer_d = '0;
            end else if (timer_q == DETECT_LAST) begin
               state_d = PROT_WAIT;
               timer_d = '0;
            end
         end
         PROT_WAIT: begin
            if (timer_q == LATCH_LAST) begin
               state_d = PROT_RETRY;
               timer_d = '0;
            end
         end
         PROT_RETRY: begin
            if (!shortS) begin
               state_d = PROT_RUN;
               timer_d = '0;
            end else if (timer_q == DETECT_LAST) begin
               state_d = PROT_LATCHED;
               timer_d = '0;
            end
         end
         PROT_LATCHED: begin
            timer_d = '0;
         end
         default: begin
            state_d = PROT_RUN;
            timer_d = '0;
         end
      endcase
      // chip_active low overrides every state, so no latch outlives a sleep request
      if (!activeS) begin
         state_d = PROT_RUN;
         timer_d = '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= PROT_RUN;
         timer_q <= '0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   wire logic shortOff = (state_q == PROT_WAIT) || (state_q == PROT_LATCHED);
   wire logic shortFault = shortOff || (state_q == PROT_RETRY);
   // the warning stays on through the retry so a host never sees it blink mid-sequence
   wire logic bridgeOn = activeS && !shortOff && !thermal_q;
   wire logic warnNext = shortFault || thermal_q;
   bridge_t bridge_q;
   logic warn_q;

   // position is taken from pos_d so the bridge sees the new angle with the engine
   always_ff @(posedge clock) begin
      if (rst) begin
         bridge_q.position <= POS_RESET;
         bridge_q.outputsOn <= 1'b0;
         warn_q <= 1'b0;
      end else begin
         bridge_q.position <= pos_d;
         bridge_q.outputsOn <= bridgeOn;
         warn_q <= warnNext;
      end
   end

   assign position = bridge_q.position;
   assign outputsOn = bridge_q.outputsOn;
   assign standbyLatched = (state_q == PROT_LATCHED);
   // open drain: only ever pull low
   assign fault_warning_n_o = 1'b0;
   assign fault_warning_n_oe = warn_q;

endmodule

`default_nettype wire

// >>> pkg/stepper_guard_pkg.sv
// constants and carrier types for the step-position and protection logic
// assumes a 25 MHz logic clock and a 512-entry electrical angle circle
package stepper_guard_pkg;

   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_HZ = 25000000;
   localparam int SHORT_DETECT_NS = 2000;
   localparam int LATCH_PERIOD_US = 256;
   localparam int SHORT_DETECT_CYC = (SHORT_DETECT_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int LATCH_PERIOD_CYC = LATCH_PERIOD_US * (CLK_HZ / 1000000);
   localparam int TIMER_W = 13;

   // -------------------------------------------------------------
   // position
   // -------------------------------------------------------------
   // one quadrant is 128 fine steps; full-step sits on the diagonal at 64
   localparam int POS_W = 9;
   localparam logic [8:0] QUAD_SPAN = 9'h080;
   localparam logic [8:0] DIAG_OFFSET = 9'h040;
   localparam logic [8:0] POS_RESET = 9'h000;
   localparam logic [2:0] RES_RESET = 3'h0;

   // resolution code: 0 full, 1 half, 2 quarter, 3 1/8, 4 1/16, 5 1/32, 6 1/64, 7 1/128
   typedef enum logic [2:0] {
      RES_FULL, RES_HALF, RES_QUARTER, RES_EIGHTH,
      RES_16TH, RES_32ND, RES_64TH, RES_128TH
   } resolution_t;

   typedef enum {
      PROT_RUN, PROT_DETECT, PROT_WAIT, PROT_RETRY, PROT_LATCHED
   } prot_state_t;

   typedef struct packed {
      logic stepEdge;
      logic forward;
      logic [2:0] resolution;
   } step_cmd_t;

   typedef struct packed {
      logic outputsOn;
      logic [8:0] position;
   } bridge_t;

endpackage

// >>> test/stepper_guard_sva.sv
// concurrent checks on the step remapper and protection sequencer ports
// assumes one clock domain and the bind below onto the top module
`timescale 1ns/10ps
`default_nettype none
module stepper_guard_sva
(
   input wire logic clock,
   input wire logic rst,
   input wire logic stepClk,
   input wire logic chip_active,
   input wire logic shortDetect,
   input wire logic thermal_trip,
   input wire logic [8:0] position,
   input wire logic outputsOn,
   input wire logic standbyLatched,
   input wire logic fault_warning_n_o,
   input wire logic fault_warning_n_oe
);
   // ------------------------------------------------------------
   // helper counts
   // ------------------------------------------------------------
   // no saturation: a short held past 8191 cycles would wrap
   logic [12:0] shortCnt_q;
   logic [12:0] offCnt_q;
   always_ff @(posedge clock) begin
      shortCnt_q <= (rst || !shortDetect) ? 13'h0000 : shortCnt_q + 13'h0001;
      offCnt_q <= (rst || outputsOn) ? 13'h0000 : offCnt_q + 13'h0001;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   property p_pinLow; fault_warning_n_o == 1'b0; endproperty
   a_pinLow: assert property (p_pinLow) else $error("pin data high");
   property p_shortOff; shortCnt_q == 13'h0039 |-> !outputsOn && fault_warning_n_oe; endproperty
   a_shortOff: assert property (p_shortOff) else $error("short kept on");
   property p_retry;
      $rose(outputsOn) && shortCnt_q > 13'h0100 |-> offCnt_q >= 13'h18fc && offCnt_q <= 13'h1904;
   endproperty
   a_retry: assert property (p_retry) else $error("retry time");
   property p_latch; $rose(outputsOn) && shortCnt_q > 13'h0100 |-> ##[40:60] standbyLatched;
   endproperty
   a_latch: assert property (p_latch) else $error("no latch");
   property p_standby; standbyLatched [*2] |-> !outputsOn && fault_warning_n_oe; endproperty
   a_standby: assert property (p_standby) else $error("latch outputs");
   property p_hold; standbyLatched && chip_active && $past(chip_active, 4) |=> standbyLatched;
   endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_therm; thermal_trip [*5] |-> fault_warning_n_oe && !outputsOn; endproperty
   a_therm: assert property (p_therm) else $error("thermal");
   property p_posHold; !stepClk [*8] |-> $stable(position); endproperty
   a_posHold: assert property (p_posHold) else $error("moved");
   property p_glitch;
      $past(outputsOn) && shortCnt_q > 13'h0000 && shortCnt_q < 13'h0028 && chip_active
         && !thermal_trip |-> outputsOn;
   endproperty
   a_glitch: assert property (p_glitch) else $error("early off");
endmodule
bind stepper_mode_switch_and_fault_latch stepper_guard_sva u_sva (
   .clock(clock), .rst(rst), .stepClk(stepClk), .chip_active(chip_active),
   .shortDetect(shortDetect), .thermal_trip(thermal_trip), .position(position),
   .outputsOn(outputsOn), .standbyLatched(standbyLatched),
   .fault_warning_n_o(fault_warning_n_o), .fault_warning_n_oe(fault_warning_n_oe)
);
`default_nettype wire

// >>> test/host_model.sv
// host controller model: step pulses, mode pins and chip enable
// assumes requests arrive on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module host_model
(
   input wire logic clock,
   input wire logic go,
   input wire logic [2:0] res,
   input wire logic sleep,
   output logic stepClk = 1'b0,
   output logic [2:0] resOut = 3'h0,
   output logic chip_active = 1'b1
);
   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   // three clocks high and at least four low, so the pin synchroniser never misses one
   int cnt = 0;
   always @(negedge clock) begin
      resOut <= res;
      chip_active <= !sleep;
      stepClk <= cnt > 3;
      if (cnt == 0 && go) begin
         cnt <= 6;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the step remapper and protection sequencer
// assumes a pull-up on the warning pin; host model drives step pins
`timescale 1ns/10ps
`default_nettype none
module testbench
   import stepper_guard_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic sleep = 1'b0;
   logic shortDetect = 1'b0;
   logic thermal_trip = 1'b0;
   logic [2:0] res = 3'h0;
   logic [2:0] resOut;
   logic [8:0] position;
   logic stepClk, chip_active, outputsOn, standbyLatched, warnO, warnOe;
   wire warnPin_n = warnOe ? warnO : 1'b1;
   wire [8:0] flags = {6'h00, outputsOn, standbyLatched, warnPin_n};
   int mismatches = 0;
   int cmp_count = 0;
   always #20 clock = ~clock;
   host_model u_host (.clock(clock), .go(go), .res(res), .sleep(sleep), .stepClk(stepClk),
      .resOut(resOut), .chip_active(chip_active));
   // reverse running is left untested: direction is tied forward
   stepper_mode_switch_and_fault_latch u_dut (.clock(clock), .rst(rst), .stepClk(stepClk),
      .forward(1'b1), .resolution_sel0(resOut[0]), .resolution_sel1(resOut[1]),
      .resolution_sel2(resOut[2]), .chip_active(chip_active), .shortDetect(shortDetect),
      .thermal_trip(thermal_trip), .position(position), .outputsOn(outputsOn),
      .standbyLatched(standbyLatched), .fault_warning_n_o(warnO), .fault_warning_n_oe(warnOe));
   // ------------------------------------------------------------
   // helpers and scenarios
   // ------------------------------------------------------------
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic results;
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic stepTable;
      logic [2:0] rt [16] = '{3'h2, 3'h4, 3'h0, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h0,
         3'h1, 3'h3, 3'h5, 3'h6, 3'h7, 3'h3};
      logic [8:0] pt [16] = '{9'h020, 9'h028, 9'h040, 9'h060, 9'h068, 9'h070, 9'h078,
         9'h080, 9'h0c0, 9'h140, 9'h180, 9'h190, 9'h194, 9'h196, 9'h197, 9'h1a0};
      logic [8:0] prev = 9'h000;
      for (int i = 0; i < 16; i++) begin
         res <= rt[i];
         cyc(6);
         chk(position, prev);
         go <= 1'b1;
         cyc(1);
         go <= 1'b0;
         cyc(12);
         chk(position, pt[i]);
         prev = pt[i];
      end
   endtask
   task automatic shortRetry;
      shortDetect = 1'b1;
      cyc(SHORT_DETECT_CYC - 10);
      shortDetect = 1'b0;
      cyc(10);
      chk(flags, 9'h005);
      shortDetect = 1'b1;
      cyc(SHORT_DETECT_CYC + 8);
      chk(flags, 9'h000);
      shortDetect = 1'b0;
      cyc(LATCH_PERIOD_CYC - 20);
      chk(flags, 9'h000);
      cyc(80);
      chk(flags, 9'h005);
   endtask
   task automatic shortLatch;
      shortDetect = 1'b1;
      cyc(SHORT_DETECT_CYC + LATCH_PERIOD_CYC + 80);
      chk(flags, 9'h002);
      shortDetect = 1'b0;
      cyc(20);
      chk(flags, 9'h002);
      sleep <= 1'b1;
      cyc(6);
      sleep <= 1'b0;
      cyc(10);
      chk(flags, 9'h005);
   endtask
   task automatic thermal;
      thermal_trip = 1'b1;
      cyc(8);
      chk(flags, 9'h000);
      thermal_trip = 1'b0;
      cyc(8);
      chk(flags, 9'h005);
   endtask
   initial begin
      cyc(2);
      chk(flags, 9'h001);
      chk(position, 9'h000);
      rst = 1'b0;
      cyc(4);
      stepTable;
      shortRetry;
      shortLatch;
      thermal;
      results;
   end
endmodule
`default_nettype wire
